// ---- src/rcr_config_pair.sv ----
/*
 * Register pair holding the multiphase regulator configuration, plus the
 * turn-on delay byte. Decodes phase count, voltage source, loop test and
 * overcurrent latchoff from the two copies.
 * Assumes the serial command front end delivers one write or read per
 * cycle as a command code with strobes, synchronous to i_clk_sys.
 */
`timescale 1ns/100ps

module rcr_config_pair #(
	parameter int CODE_W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_cmd_code,
	input wire logic [7:0] i_wr_data,
	input wire logic [CODE_W-1:0] i_output_voltage_code,
	input wire logic [CODE_W-1:0] i_voltage_identification_inputs,
	input wire logic i_current_limit_timeout,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic [3:0] o_phase_count,
	output logic [rcr_pkg::RCR_MAX_PHASES-1:0] o_phase_enable,
	output logic [CODE_W-1:0] o_vout_code,
	output logic o_loop_test_enable,
	output logic o_latchoff_enable,
	output logic o_latched_off,
	output logic [7:0] o_turn_on_delay
);
	import rcr_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] cfg_pri;
		logic [7:0] cfg_dup;
		logic [7:0] ton;
		logic [RCR_PHASE_W-1:0] phase_sel;
		logic [CODE_W-1:0] vout;
		logic latched;
		logic [7:0] rd_data;
		logic rd_valid;
	} rcr_state_s;

	rcr_state_s s_reg;
	rcr_state_s s_next;
	logic vsrc_both;
	logic loop_both;
	logic latch_en;

	// Thermometer mask of active phases; lowest phases always run first
	function automatic logic [RCR_MAX_PHASES-1:0] rcr_phase_mask(
		input logic [RCR_PHASE_W-1:0] sel
	);
		logic [RCR_MAX_PHASES-1:0] m;
		m = '0;
		for (int i = 0; i < RCR_MAX_PHASES; i++)
		begin
			m[i] = (i <= int'(sel));
		end
		return m;
	endfunction : rcr_phase_mask

	// ------------------------------------------------------------
	// Agreement of the two copies
	// ------------------------------------------------------------
	// A single corrupted byte must not switch the source or loop test on, so both copies vote
	assign vsrc_both = s_reg.cfg_pri[RCR_VSRC_BIT] & s_reg.cfg_dup[RCR_VSRC_BIT];
	assign loop_both = s_reg.cfg_pri[RCR_LOOP_BIT] & s_reg.cfg_dup[RCR_LOOP_BIT];
	// Latchoff is only disabled when both copies say so: fail safe
	assign latch_en = s_reg.cfg_pri[RCR_LATCH_BIT] | s_reg.cfg_dup[RCR_LATCH_BIT];

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		// Writes land only after reset release, defaults already loaded
		if (i_wr_en)
		begin
			case (i_cmd_code)
				RCR_CMD_CFG_PRI: s_next.cfg_pri = i_wr_data;
				RCR_CMD_CFG_DUP: s_next.cfg_dup = i_wr_data;
				RCR_CMD_TON_DLY: s_next.ton = i_wr_data;
				default: s_next.ton = s_reg.ton; // Unmapped writes are dropped
			endcase
		end
		// Reads answer one cycle later; unmapped codes read as zero
		if (i_rd_en)
		begin
			s_next.rd_valid = 1'b1;
			case (i_cmd_code)
				RCR_CMD_CFG_PRI: s_next.rd_data = s_reg.cfg_pri;
				RCR_CMD_CFG_DUP: s_next.rd_data = s_reg.cfg_dup;
				RCR_CMD_TON_DLY: s_next.rd_data = s_reg.ton;
				default: s_next.rd_data = RCR_UNMAPPED_DATA;
			endcase
		end
		// Phase count moves only when both copies agree; else last agreed value holds
		if (s_reg.cfg_pri[RCR_PHASE_MSB:RCR_PHASE_LSB] == s_reg.cfg_dup[RCR_PHASE_MSB:RCR_PHASE_LSB])
		begin
			s_next.phase_sel = s_reg.cfg_pri[RCR_PHASE_MSB:RCR_PHASE_LSB];
		end
		// Output voltage source select; bit 0 enters no decode at all
		if (vsrc_both)
		begin
			s_next.vout = i_output_voltage_code;
		end
		else
		begin
			s_next.vout = i_voltage_identification_inputs;
		end
		// Latchoff: a timeout latches while enabled; disabling it releases the latch
		if (!latch_en)
		begin
			s_next.latched = 1'b0;
		end
		else if (i_current_limit_timeout)
		begin
			s_next.latched = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_reg.cfg_pri <= RCR_CFG_RESET;
			s_reg.cfg_dup <= RCR_CFG_RESET;
			s_reg.ton <= RCR_TON_RESET;
			s_reg.phase_sel <= RCR_CFG_RESET[RCR_PHASE_MSB:RCR_PHASE_LSB];
			s_reg.vout <= '0;
			s_reg.latched <= 1'b0;
			s_reg.rd_data <= 8'h00;
			s_reg.rd_valid <= 1'b0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_rd_data = s_reg.rd_data;
	assign o_rd_valid = s_reg.rd_valid;
	assign o_phase_count = {1'b0, s_reg.phase_sel} + 4'h1;
	assign o_phase_enable = rcr_phase_mask(s_reg.phase_sel);
	assign o_vout_code = s_reg.vout;
	assign o_loop_test_enable = loop_both;
	assign o_latchoff_enable = latch_en;
	assign o_latched_off = s_reg.latched;
	assign o_turn_on_delay = s_reg.ton;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_phase_agree: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_reg.cfg_pri[6:4] == s_reg.cfg_dup[6:4])
		|=> (o_phase_count == {1'b0, $past(s_reg.cfg_pri[6:4])} + 4'h1))
		else $error("phase count does not follow agreed field");

	chk_phase_hold: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_reg.cfg_pri[6:4] != s_reg.cfg_dup[6:4]) |=> $stable(o_phase_count))
		else $error("phase count moved while copies disagree");

	chk_vsrc_register: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_reg.cfg_pri[3] && s_reg.cfg_dup[3]) |=> (o_vout_code == $past(i_output_voltage_code)))
		else $error("output code not taken from register");

	chk_vsrc_pins: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		!(s_reg.cfg_pri[3] && s_reg.cfg_dup[3])
		|=> (o_vout_code == $past(i_voltage_identification_inputs)))
		else $error("output code not taken from pins");

	// A copy written with its loop bit clear must shut the test off one cycle later
	chk_loop_both: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_wr_en && (i_cmd_code == RCR_CMD_CFG_PRI || i_cmd_code == RCR_CMD_CFG_DUP)
			&& !i_wr_data[RCR_LOOP_BIT])
		|=> !o_loop_test_enable)
		else $error("loop test enabled without both copies");

	chk_latch_set: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_reg.cfg_pri[1] && i_current_limit_timeout) |=> o_latched_off)
		else $error("timeout did not latch output off");

	chk_never_latch: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(!s_reg.cfg_pri[1] && !s_reg.cfg_dup[1]) |=> !o_latched_off)
		else $error("latched off while latchoff disabled in both");

	chk_dup_write: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_wr_en && i_cmd_code == RCR_CMD_CFG_DUP)
		##1 !i_wr_en
		##1 (i_rd_en && i_cmd_code == RCR_CMD_CFG_DUP && !i_wr_en)
		|=> (o_rd_valid && o_rd_data == $past(i_wr_data, 3)))
		else $error("duplicate copy does not read back its write");

	chk_rsvd_ignored: assert property (
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_wr_en && i_cmd_code == RCR_CMD_CFG_PRI
			&& i_wr_data[7:RCR_RSVD_BIT+1] == s_reg.cfg_pri[7:RCR_RSVD_BIT+1])
		|=> ($stable(o_loop_test_enable) && $stable(o_latchoff_enable)))
		else $error("reserved bit changed behaviour");

	chk_reset_defaults: assert property (
		@(posedge i_clk_sys) $rose(i_rst_n)
		|-> (s_reg.cfg_pri == RCR_CFG_RESET && s_reg.cfg_dup == RCR_CFG_RESET
			&& s_reg.ton == RCR_TON_RESET))
		else $error("defaults not loaded at reset");

endmodule : rcr_config_pair

// ---- src/rcr_pkg.sv ----
/*
 * Constants for the regulator configuration register pair: command codes,
 * field positions, reset values and read answers.
 * Assumes a serial command front end that hands over decoded command codes.
 */
package rcr_pkg;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] RCR_CMD_CFG_PRI = 8'hd2;
	localparam logic [7:0] RCR_CMD_CFG_DUP = 8'hd3;
	localparam logic [7:0] RCR_CMD_TON_DLY = 8'hd4;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RCR_CFG_RESET = 8'h72;
	localparam logic [7:0] RCR_TON_RESET = 8'h03;
	localparam logic [7:0] RCR_UNMAPPED_DATA = 8'h00;

	// ------------------------------------------------------------
	// Field positions of both configuration copies
	// ------------------------------------------------------------
	localparam int RCR_PHASE_MSB = 6;
	localparam int RCR_PHASE_LSB = 4;
	localparam int RCR_VSRC_BIT = 3;
	localparam int RCR_LOOP_BIT = 2;
	localparam int RCR_LATCH_BIT = 1;
	localparam int RCR_RSVD_BIT = 0;
	localparam int RCR_PHASE_W = 3;
	localparam int RCR_MAX_PHASES = 8;

endpackage : rcr_pkg

// ---- tb/rcr_host_model.sv ----
/*
 * Host model: issues single-byte writes and reads on the command port.
 * Assumes the bench clock; requests change only at falling edges.
 */
`timescale 1ns/100ps
module rcr_host_model (
	input wire logic i_clk_sys,
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_valid,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_cmd_code,
	output logic [7:0] o_wr_data
);
	// Idle port, strobes low
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_cmd_code = 8'h00;
		o_wr_data = 8'h00;
	end
	// One byte write, held across exactly one rising edge
	task automatic wr(input logic [7:0] code, input logic [7:0] data);
		@(negedge i_clk_sys);
		o_wr_en = 1'b1;
		o_cmd_code = code;
		o_wr_data = data;
		@(negedge i_clk_sys);
		o_wr_en = 1'b0;
		o_wr_data = ~data; // Stale data never looks valid
	endtask : wr
	// One byte read; the answer is waited for under a bound
	task automatic rd(input logic [7:0] code, output logic [7:0] data);
		int n;
		@(negedge i_clk_sys);
		o_rd_en = 1'b1;
		o_cmd_code = code;
		@(negedge i_clk_sys);
		o_rd_en = 1'b0;
		n = 0;
		while (i_rd_valid !== 1'b1 && n < 4)
		begin
			@(negedge i_clk_sys);
			n++;
		end
		data = (i_rd_valid === 1'b1) ? i_rd_data : ~i_rd_data;
	endtask : rd
endmodule : rcr_host_model

// ---- tb/regulator_config_register_pair_tb.sv ----
/*
 * Self-checking bench for the configuration register pair.
 * Assumes rcr_pkg and rcr_host_model are compiled first.
 */
`timescale 1ns/100ps
module regulator_config_register_pair_tb;
	import rcr_pkg::*;
	logic clk, rst_n, wr_en, rd_en, tmo, rd_valid, loop_en, latch_en, latched;
	logic [7:0] cmd, wdata, ovc, pins, rd_data, phase_en, vout, ton, rv;
	logic [3:0] phase_count;
	int err_total = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	rcr_config_pair dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_wr_en(wr_en),
		.i_rd_en(rd_en), .i_cmd_code(cmd), .i_wr_data(wdata), .i_output_voltage_code(ovc),
		.i_voltage_identification_inputs(pins), .i_current_limit_timeout(tmo),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_phase_count(phase_count),
		.o_phase_enable(phase_en), .o_vout_code(vout), .o_loop_test_enable(loop_en),
		.o_latchoff_enable(latch_en), .o_latched_off(latched), .o_turn_on_delay(ton));
	rcr_host_model host (.i_clk_sys(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
		.o_wr_en(wr_en), .o_rd_en(rd_en), .o_cmd_code(cmd), .o_wr_data(wdata));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rdchk(input logic [7:0] code, input logic [7:0] exp);
		host.rd(code, rv);
		chk(rv, exp);
	endtask : rdchk
	// Both copies get the same byte, then decode settles
	task automatic both(input logic [7:0] d);
		host.wr(RCR_CMD_CFG_PRI, d);
		host.wr(RCR_CMD_CFG_DUP, d);
		repeat (3) @(negedge clk);
	endtask : both
	task automatic pulse_tmo;
		tmo = 1'b1;
		@(negedge clk);
		tmo = 1'b0;
		@(negedge clk);
	endtask : pulse_tmo
	task automatic complete_run;
		$display("Mismatches %0d of %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		tmo = 1'b0;
		ovc = 8'h5a;
		pins = 8'ha5;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({4'h0, phase_count}, 8'h08);
		chk(phase_en, 8'hff);
		rdchk(RCR_CMD_CFG_PRI, RCR_CFG_RESET);
		rdchk(RCR_CMD_CFG_DUP, RCR_CFG_RESET);
		rdchk(RCR_CMD_TON_DLY, RCR_TON_RESET);
		chk(vout, pins);
		for (int c = 0; c < 8; c++)
		begin
			both({1'b0, c[2:0], 4'h0});
			chk({4'h0, phase_count}, 8'(c + 1));
			chk(phase_en, 8'((16'h1 << (c + 1)) - 1));
		end
		chk({7'h0, latch_en}, 8'h00);
		pulse_tmo();
		chk({7'h0, latched}, 8'h00);
		// Primary alone cannot switch the source or the loop test
		host.wr(RCR_CMD_CFG_PRI, 8'h0e);
		repeat (3) @(negedge clk);
		chk(vout, pins);
		chk({4'h0, phase_count}, 8'h08);
		chk({7'h0, loop_en}, 8'h00);
		chk({7'h0, latch_en}, 8'h01);
		pulse_tmo();
		chk({7'h0, latched}, 8'h01);
		host.wr(RCR_CMD_CFG_DUP, 8'h0e);
		repeat (3) @(negedge clk);
		chk(vout, ovc);
		chk({7'h0, loop_en}, 8'h01);
		// Reserved bit alone steers nothing; latch released
		both(8'h01);
		chk({7'h0, latched}, 8'h00);
		// Flipping only the reserved bit of the primary must leave every enable alone
		host.wr(RCR_CMD_CFG_PRI, 8'h00);
		chk({3'h0, loop_en, vout == pins, latch_en, phase_count == 4'h1}, 8'h05);
		rdchk(RCR_CMD_CFG_DUP, 8'h01);
		// Write then read the duplicate with one idle cycle between
		host.wr(RCR_CMD_CFG_DUP, 8'h73);
		rdchk(RCR_CMD_CFG_DUP, 8'h73);
		host.wr(RCR_CMD_TON_DLY, 8'hc9);
		host.wr(8'hd5, 8'hff);
		rdchk(RCR_CMD_TON_DLY, 8'hc9);
		chk(ton, 8'hc9);
		rdchk(8'hd5, RCR_UNMAPPED_DATA);
		// Reset in mid-run must bring back the turn-on delay and duplicate copy defaults over written values
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk(ton, RCR_TON_RESET);
		rdchk(RCR_CMD_CFG_DUP, RCR_CFG_RESET);
		rdchk(RCR_CMD_TON_DLY, RCR_TON_RESET);
		complete_run();
	end
	// Watchdog, far beyond the roughly 130 cycles the tests need
	initial
	begin
		#(50 * 4000);
		err_total++;
		complete_run();
	end
endmodule : regulator_config_register_pair_tb
